// ---- inc/sec_regs.vh ----
// constants of the serial eeprom controller: timing, codes, signature and serial framing
// assumes a 125 MHz CLK and a 128 x 8 three-wire eeprom with a ready/busy indication on its data line
`ifndef SEC_REGS_VH
`define SEC_REGS_VH

// --------------------------------------------------------------------------
// timing
// --------------------------------------------------------------------------
`define SEC_CLK_PERIOD_NS 8
`define SEC_SCLK_HALF_NS 500
`define SEC_SCLK_HALF_CYC ((`SEC_SCLK_HALF_NS + `SEC_CLK_PERIOD_NS - 1) / `SEC_CLK_PERIOD_NS)
`define SEC_TIMEOUT_MS 30
`define SEC_TIMEOUT_CYC (`SEC_TIMEOUT_MS * 1000000 / `SEC_CLK_PERIOD_NS)

// --------------------------------------------------------------------------
// boot load
// --------------------------------------------------------------------------
`define SEC_SIGNATURE 8'ha5
`define SEC_SIG_LOC 7'h00
`define SEC_ADDR_BYTES 3'h6

// --------------------------------------------------------------------------
// command codes of the command register
// --------------------------------------------------------------------------
`define SEC_CMD_READ 3'h0
`define SEC_CMD_ERASE_WRITE_DISABLE_CMD 3'h1
`define SEC_CMD_ERASE_WRITE_ENABLE_CMD 3'h2
`define SEC_CMD_WRITE 3'h3
`define SEC_CMD_WRITE_ALL_CMD 3'h4
`define SEC_CMD_ERASE 3'h5
`define SEC_CMD_ERASE_ALL_CMD 3'h6
`define SEC_CMD_RELOAD 3'h7

// --------------------------------------------------------------------------
// serial opcodes and fixed address patterns of the special commands
// --------------------------------------------------------------------------
`define SEC_OP_READ 2'h2
`define SEC_OP_WRITE 2'h1
`define SEC_OP_ERASE 2'h3
`define SEC_OP_SPECIAL 2'h0
`define SEC_ADR_ERASE_WRITE_ENABLE_CMD 7'h60
`define SEC_ADR_ERASE_WRITE_DISABLE_CMD 7'h00
`define SEC_ADR_ERASE_ALL_CMD 7'h40
`define SEC_ADR_WRITE_ALL_CMD 7'h20
`define SEC_BITS_SHORT 5'h0a
`define SEC_BITS_LONG 5'h12

`endif

// ---- hdl/sec_sync.v ----
// three-stage synchroniser with agreement filter for one pin input
// assumes the input is asynchronous to CLK
`timescale 1ns/10ps
module sec_sync (
   input wire CLK,
   input wire RST,
   input wire D,
   output reg Q
);
   reg s1_reg;
   reg s2_reg;
   reg s3_reg;

   // only the second and third stages are compared; the first feeds nothing else
   always @(posedge CLK)
   begin
      if (RST)
      begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
         Q <= 1'b0;
      end
      else
      begin
         s1_reg <= D;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg)
            Q <= s3_reg;
      end
   end
endmodule

// ---- hdl/sec_ctrl.v ----
// serial eeprom controller: boot load of the station address and software commands
// assumes a single 128 x 8 three-wire eeprom; software drives the command and data ports
`timescale 1ns/10ps
`include "sec_regs.vh"
module sec_ctrl #(
   parameter integer TIMEOUT_CYC = `SEC_TIMEOUT_CYC
) (
   input wire CLK,
   input wire RST,
   input wire SOFT_RESET,
   input wire IF_ENABLE,
   input wire GP_DATA_OUT,
   input wire GP_CLOCK_OUT,
   input wire CMD_WRITE,
   input wire [2:0] CMD_CODE_IN,
   input wire [6:0] CMD_LOCATION_IN,
   input wire CMD_BUSY_IN,
   input wire DATA_WRITE,
   input wire [7:0] DATA_IN,
   input wire STA_WRITE_LOW,
   input wire STA_WRITE_HIGH,
   input wire [31:0] STA_WDATA,
   output wire COMMAND_BUSY_FLAG,
   output reg [2:0] COMMAND_CODE_FIELD,
   output reg [6:0] LOCATION_FIELD,
   output reg RESPONSE_TIMEOUT_FLAG,
   output reg ADDR_LOADED,
   output reg [7:0] PROM_DATA,
   output wire [31:0] STATION_ADDR_LOW,
   output wire [15:0] STATION_ADDR_HIGH,
   output reg PROM_CS,
   output reg SERIAL_CLOCK_PIN,
   output reg SERIAL_DATA_PIN_O,
   output reg SERIAL_DATA_PIN_OE,
   input wire SERIAL_DATA_PIN_I
);

   // -----------------------------------------------------------------------
   // constants and states
   // -----------------------------------------------------------------------
   localparam integer HALF_LAST_INT = `SEC_SCLK_HALF_CYC - 1;
   localparam integer TMO_LAST_INT = TIMEOUT_CYC - 1;
   localparam [7:0] HALF_LAST = HALF_LAST_INT[7:0];
   localparam [21:0] TMO_LAST = TMO_LAST_INT[21:0];
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_SETUP = 3'h1;
   localparam [2:0] ST_HIGH = 3'h2;
   localparam [2:0] ST_GAP = 3'h3;
   localparam [2:0] ST_POLL = 3'h4;
   localparam [2:0] ST_FINISH = 3'h5;

   // -----------------------------------------------------------------------
   // functions
   // -----------------------------------------------------------------------
   // serial word: start bit, opcode, address, data; msb leaves first
   function [17:0] frame_word;
      input [2:0] code;
      input [6:0] loc;
      input [7:0] data;
      begin
         case (code)
            `SEC_CMD_WRITE: frame_word = {1'b1, `SEC_OP_WRITE, loc, data};
            `SEC_CMD_WRITE_ALL_CMD: frame_word = {1'b1, `SEC_OP_SPECIAL, `SEC_ADR_WRITE_ALL_CMD, data};
            `SEC_CMD_ERASE: frame_word = {1'b1, `SEC_OP_ERASE, loc, 8'h00};
            `SEC_CMD_ERASE_ALL_CMD: frame_word = {1'b1, `SEC_OP_SPECIAL, `SEC_ADR_ERASE_ALL_CMD, 8'h00};
            `SEC_CMD_ERASE_WRITE_ENABLE_CMD: frame_word = {1'b1, `SEC_OP_SPECIAL, `SEC_ADR_ERASE_WRITE_ENABLE_CMD, 8'h00};
            `SEC_CMD_ERASE_WRITE_DISABLE_CMD: frame_word = {1'b1, `SEC_OP_SPECIAL, `SEC_ADR_ERASE_WRITE_DISABLE_CMD, 8'h00};
            default: frame_word = {1'b1, `SEC_OP_READ, loc, 8'h00};
         endcase
      end
   endfunction

   // bits driven by the controller
   function [4:0] out_bits;
      input [2:0] code;
      begin
         if (code == `SEC_CMD_WRITE || code == `SEC_CMD_WRITE_ALL_CMD)
            out_bits = `SEC_BITS_LONG;
         else
            out_bits = `SEC_BITS_SHORT;
      end
   endfunction

   // commands that keep the eeprom busy afterwards
   function needs_poll;
      input [2:0] code;
      begin
         needs_poll = (code == `SEC_CMD_WRITE) || (code == `SEC_CMD_WRITE_ALL_CMD) ||
            (code == `SEC_CMD_ERASE) || (code == `SEC_CMD_ERASE_ALL_CMD);
      end
   endfunction

   // -----------------------------------------------------------------------
   // registers
   // -----------------------------------------------------------------------
   reg [7:0] div_reg;
   reg tick_reg;
   reg [2:0] state_reg;
   reg busy_reg;
   reg loading_reg;
   reg launch_reg;
   reg [2:0] load_idx_reg;
   reg [2:0] op_reg;
   reg [17:0] sh_reg;
   reg [4:0] cnt_reg;
   reg [4:0] nout_reg;
   reg [4:0] ntot_reg;
   reg poll_reg;
   reg [7:0] rx_reg;
   reg [21:0] tmo_reg;
   reg cs_reg;
   reg sclk_reg;
   reg oe_reg;
   reg [47:0] sta_reg;
   wire din_s;
   wire [4:0] cnt_next;
   wire tmo_hit;
   wire sw_start;
   wire [6:0] start_loc;

   assign COMMAND_BUSY_FLAG = busy_reg;
   assign STATION_ADDR_LOW = sta_reg[31:0];
   assign STATION_ADDR_HIGH = sta_reg[47:32];
   assign cnt_next = cnt_reg + 5'h01;
   assign tmo_hit = (tmo_reg == TMO_LAST);
   // a write while busy is refused, so the running command cannot be disturbed
   assign sw_start = CMD_WRITE & CMD_BUSY_IN & ~busy_reg;
   assign start_loc = (load_idx_reg == 3'h0) ? `SEC_SIG_LOC : {4'h0, load_idx_reg};

   sec_sync u_din_sync (
      .CLK(CLK),
      .RST(RST),
      .D(SERIAL_DATA_PIN_I),
      .Q(din_s)
   );

   // -----------------------------------------------------------------------
   // serial clock divider: one tick per half period
   // -----------------------------------------------------------------------
   always @(posedge CLK)
   begin
      if (RST || state_reg == ST_IDLE)
      begin
         div_reg <= 8'h00;
         tick_reg <= 1'b0;
      end
      else if (div_reg == HALF_LAST)
      begin
         div_reg <= 8'h00;
         tick_reg <= 1'b1;
      end
      else
      begin
         div_reg <= div_reg + 8'h01;
         tick_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------------
   always @(posedge CLK)
   begin
      if (RST)
      begin
         state_reg <= ST_IDLE;
         busy_reg <= 1'b1;
         loading_reg <= 1'b1;
         launch_reg <= 1'b1;
         load_idx_reg <= 3'h0;
         op_reg <= `SEC_CMD_READ;
         COMMAND_CODE_FIELD <= `SEC_CMD_READ;
         LOCATION_FIELD <= 7'h00;
         sh_reg <= 18'h00000;
         cnt_reg <= 5'h00;
         nout_reg <= 5'h00;
         ntot_reg <= 5'h00;
         poll_reg <= 1'b0;
         rx_reg <= 8'h00;
         tmo_reg <= 22'h000000;
         cs_reg <= 1'b0;
         sclk_reg <= 1'b0;
         oe_reg <= 1'b0;
         RESPONSE_TIMEOUT_FLAG <= 1'b0;
         ADDR_LOADED <= 1'b0;
         PROM_DATA <= 8'h00;
         sta_reg <= 48'h000000000000;
      end
      else if (SOFT_RESET)
      begin
         // soft reset aborts any command and restarts the boot load; address is kept
         state_reg <= ST_IDLE;
         busy_reg <= 1'b1;
         loading_reg <= 1'b1;
         launch_reg <= 1'b1;
         load_idx_reg <= 3'h0;
         cs_reg <= 1'b0;
         sclk_reg <= 1'b0;
         oe_reg <= 1'b0;
         RESPONSE_TIMEOUT_FLAG <= 1'b0;
         ADDR_LOADED <= 1'b0;
      end
      else
      begin
         if (DATA_WRITE && !busy_reg)
            PROM_DATA <= DATA_IN;
         if (STA_WRITE_LOW && !loading_reg)
            sta_reg[31:0] <= STA_WDATA;
         if (STA_WRITE_HIGH && !loading_reg)
            sta_reg[47:32] <= STA_WDATA[15:0];
         if (state_reg != ST_IDLE)
            tmo_reg <= tmo_reg + 22'h000001;
         if (state_reg != ST_IDLE && tmo_hit)
         begin
            // no answer in time: drop the frame and report
            state_reg <= ST_IDLE;
            cs_reg <= 1'b0;
            sclk_reg <= 1'b0;
            oe_reg <= 1'b0;
            busy_reg <= 1'b0;
            loading_reg <= 1'b0;
            RESPONSE_TIMEOUT_FLAG <= 1'b1;
         end
         else
         begin
            case (state_reg)
               ST_IDLE:
               begin
                  tmo_reg <= 22'h000000;
                  if (launch_reg)
                  begin
                     launch_reg <= 1'b0;
                     op_reg <= `SEC_CMD_READ;
                     sh_reg <= frame_word(`SEC_CMD_READ, start_loc, 8'h00);
                     nout_reg <= `SEC_BITS_SHORT;
                     ntot_reg <= `SEC_BITS_LONG;
                     poll_reg <= 1'b0;
                     cnt_reg <= 5'h00;
                     cs_reg <= 1'b1;
                     oe_reg <= 1'b1;
                     state_reg <= ST_SETUP;
                  end
                  else if (sw_start)
                  begin
                     COMMAND_CODE_FIELD <= CMD_CODE_IN;
                     LOCATION_FIELD <= CMD_LOCATION_IN;
                     busy_reg <= 1'b1;
                     RESPONSE_TIMEOUT_FLAG <= 1'b0;
                     if (CMD_CODE_IN == `SEC_CMD_RELOAD)
                     begin
                        loading_reg <= 1'b1;
                        launch_reg <= 1'b1;
                        load_idx_reg <= 3'h0;
                        ADDR_LOADED <= 1'b0;
                     end
                     else
                     begin
                        op_reg <= CMD_CODE_IN;
                        sh_reg <= frame_word(CMD_CODE_IN, CMD_LOCATION_IN, PROM_DATA);
                        nout_reg <= out_bits(CMD_CODE_IN);
                        ntot_reg <= (CMD_CODE_IN == `SEC_CMD_READ) ? `SEC_BITS_LONG : out_bits(CMD_CODE_IN);
                        poll_reg <= needs_poll(CMD_CODE_IN);
                        cnt_reg <= 5'h00;
                        cs_reg <= 1'b1;
                        oe_reg <= 1'b1;
                        state_reg <= ST_SETUP;
                     end
                  end
               end
               ST_SETUP:
                  if (tick_reg)
                  begin
                     sclk_reg <= 1'b1;
                     state_reg <= ST_HIGH;
                  end
               ST_HIGH:
                  if (tick_reg)
                  begin
                     sclk_reg <= 1'b0;
                     // the eeprom presents read bits after the rising edge; take them before falling
                     if (cnt_reg >= nout_reg)
                        rx_reg <= {rx_reg[6:0], din_s};
                     sh_reg <= {sh_reg[16:0], 1'b0};
                     cnt_reg <= cnt_next;
                     oe_reg <= (cnt_next < nout_reg);
                     if (cnt_next == ntot_reg)
                     begin
                        cs_reg <= 1'b0;
                        oe_reg <= 1'b0;
                        state_reg <= poll_reg ? ST_GAP : ST_FINISH;
                     end
                     else
                        state_reg <= ST_SETUP;
                  end
               ST_GAP:
                  // one half period with select low before the ready check
                  if (tick_reg)
                  begin
                     cs_reg <= 1'b1;
                     state_reg <= ST_POLL;
                  end
               ST_POLL:
                  if (tick_reg && din_s)
                  begin
                     cs_reg <= 1'b0;
                     state_reg <= ST_FINISH;
                  end
               ST_FINISH:
               begin
                  state_reg <= ST_IDLE;
                  if (loading_reg)
                  begin
                     if (load_idx_reg == 3'h0 && rx_reg != `SEC_SIGNATURE)
                     begin
                        loading_reg <= 1'b0;
                        busy_reg <= 1'b0;
                     end
                     else
                     begin
                        if (load_idx_reg != 3'h0)
                           sta_reg[load_idx_reg * 8 - 8 +: 8] <= rx_reg;
                        if (load_idx_reg == `SEC_ADDR_BYTES)
                        begin
                           loading_reg <= 1'b0;
                           busy_reg <= 1'b0;
                           ADDR_LOADED <= 1'b1;
                        end
                        else
                        begin
                           load_idx_reg <= load_idx_reg + 3'h1;
                           launch_reg <= 1'b1;
                        end
                     end
                  end
                  else
                  begin
                     if (op_reg == `SEC_CMD_READ)
                        PROM_DATA <= rx_reg;
                     busy_reg <= 1'b0;
                  end
               end
               default:
                  state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------------
   // pin drivers
   // -----------------------------------------------------------------------
   // disabled interface hands both pins to the general outputs and keeps the part deselected
   always @(posedge CLK)
   begin
      if (RST)
      begin
         PROM_CS <= 1'b0;
         SERIAL_CLOCK_PIN <= 1'b0;
         SERIAL_DATA_PIN_O <= 1'b0;
         SERIAL_DATA_PIN_OE <= 1'b0;
      end
      else if (IF_ENABLE)
      begin
         PROM_CS <= cs_reg;
         SERIAL_CLOCK_PIN <= sclk_reg;
         SERIAL_DATA_PIN_O <= sh_reg[17];
         SERIAL_DATA_PIN_OE <= oe_reg;
      end
      else
      begin
         PROM_CS <= 1'b0;
         SERIAL_CLOCK_PIN <= GP_CLOCK_OUT;
         SERIAL_DATA_PIN_O <= GP_DATA_OUT;
         SERIAL_DATA_PIN_OE <= 1'b1;
      end
   end
endmodule

// ---- test/sec_prom_model.sv ----
// partner model: a 128 x 8 three-wire eeprom with a ready level on its data line while polled
// assumes sclk and cs come straight from the controller pins and din is the resolved data line
`timescale 1ns/10ps
`include "sec_regs.vh"
module sec_prom_model #(
   parameter integer BUSY_NS = 5000
) (
   input wire sclk,
   input wire cs,
   input wire din,
   input wire stall,
   output reg dq_o,
   output reg dq_oe
);
   reg [7:0] mem [0:127];
   reg [17:0] sh;
   reg [9:0] hdr = 0;
   reg en = 0;
   reg poll = 0;
   integer cnt = 0;
   integer k;
   time done_t = 0;
   initial dq_oe = 0;
   initial dq_o = 0;
   // ------------------------------------------------------------
   // frame capture, msb first on the rising serial clock
   // ------------------------------------------------------------
   always @(posedge sclk)
      if (cs)
      begin
         cnt = cnt + 1;
         sh = {sh[16:0], din};
         if (cnt == 10)
            hdr = sh[9:0];
         if (cnt > 10 && cnt < 19 && hdr[9] && hdr[8:7] == `SEC_OP_READ)
         begin
            dq_oe = 1;
            dq_o = mem[hdr[6:0]][18 - cnt];
         end
      end
   // ------------------------------------------------------------
   // decode on chip select release; a stalled part never reports ready
   // ------------------------------------------------------------
   always @(negedge cs)
   begin
      dq_oe = 0;
      if (poll)
         poll = 0;
      else if (cnt >= 10 && hdr[9])
      begin
         if (hdr[8:7] == `SEC_OP_WRITE && en)
            mem[hdr[6:0]] = sh[7:0];
         if (hdr[8:7] == `SEC_OP_ERASE && en)
            mem[hdr[6:0]] = 8'hff;
         for (k = 0; k < 128; k = k + 1)
            if (hdr == {1'b1, `SEC_OP_SPECIAL, `SEC_ADR_ERASE_ALL_CMD} && en)
               mem[k] = 8'hff;
            else if (hdr == {1'b1, `SEC_OP_SPECIAL, `SEC_ADR_WRITE_ALL_CMD} && en)
               mem[k] = sh[7:0];
         if (hdr == {1'b1, `SEC_OP_SPECIAL, `SEC_ADR_ERASE_WRITE_ENABLE_CMD})
            en = 1;
         if (hdr == {1'b1, `SEC_OP_SPECIAL, `SEC_ADR_ERASE_WRITE_DISABLE_CMD})
            en = 0;
         poll = hdr[8:7] != `SEC_OP_READ && (hdr[8:7] != `SEC_OP_SPECIAL || ^hdr[6:5]);
         done_t = $time + (en ? BUSY_NS : 0);
      end
      cnt = 0;
   end
   always @(posedge cs)
      if (poll)
      begin
         dq_oe = 1;
         dq_o = 0;
         while ($time < done_t || stall)
            #8;
         dq_o = 1;
      end
endmodule

// ---- test/sec_ctrl_checker.sv ----
// concurrent checks on the ports of the serial eeprom controller
// assumes one CLK domain with synchronous active high RST
`timescale 1ns/10ps
`include "sec_regs.vh"
module sec_ctrl_checker #(
   parameter integer TIMEOUT_CYC = 20000
) (
   input wire CLK,
   input wire RST,
   input wire SOFT_RESET,
   input wire IF_ENABLE,
   input wire GP_DATA_OUT,
   input wire GP_CLOCK_OUT,
   input wire CMD_WRITE,
   input wire [2:0] CMD_CODE_IN,
   input wire [6:0] CMD_LOCATION_IN,
   input wire CMD_BUSY_IN,
   input wire COMMAND_BUSY_FLAG,
   input wire [2:0] COMMAND_CODE_FIELD,
   input wire [6:0] LOCATION_FIELD,
   input wire RESPONSE_TIMEOUT_FLAG,
   input wire ADDR_LOADED,
   input wire PROM_CS,
   input wire SERIAL_CLOCK_PIN,
   input wire SERIAL_DATA_PIN_O,
   input wire SERIAL_DATA_PIN_OE
);
   reg [31:0] busy_cnt_reg;
   wire cmd_take = CMD_WRITE && CMD_BUSY_IN && !COMMAND_BUSY_FLAG && !SOFT_RESET;
   always @(posedge CLK)
      if (RST || !COMMAND_BUSY_FLAG)
         busy_cnt_reg <= 32'h0;
      else
         busy_cnt_reg <= busy_cnt_reg + 32'h1;
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   busy_start_a: assert property (cmd_take |=> COMMAND_BUSY_FLAG)
      else $error("busy did not rise after an accepted command");
   cmd_capture_a: assert property (cmd_take |=> COMMAND_CODE_FIELD == $past(CMD_CODE_IN) &&
      LOCATION_FIELD == $past(CMD_LOCATION_IN)) else $error("command fields not captured");
   busy_hold_a: assert property (COMMAND_BUSY_FLAG && CMD_WRITE |=> $stable(COMMAND_CODE_FIELD) &&
      $stable(LOCATION_FIELD)) else $error("command fields changed while busy");
   // a load keeps busy over up to seven frames, each with its own timeout
   timeout_bound_a: assert property (busy_cnt_reg <= 7 * (TIMEOUT_CYC + 8))
      else $error("busy outlasted the timeout");
   timeout_abort_a: assert property ($rose(RESPONSE_TIMEOUT_FLAG) |-> ##[0:2]
      (!PROM_CS && !SERIAL_CLOCK_PIN && !COMMAND_BUSY_FLAG)) else $error("timeout did not abort");
   pins_release_a: assert property ((!IF_ENABLE && $stable(GP_CLOCK_OUT) && $stable(GP_DATA_OUT)) [*3] |->
      SERIAL_CLOCK_PIN == GP_CLOCK_OUT && SERIAL_DATA_PIN_O == GP_DATA_OUT && SERIAL_DATA_PIN_OE)
      else $error("pins do not follow general outputs");
   start_bit_a: assert property ($rose(PROM_CS) && SERIAL_DATA_PIN_OE && IF_ENABLE |->
      SERIAL_DATA_PIN_O && !SERIAL_CLOCK_PIN) else $error("frame does not open with a start bit");
   clock_gated_a: assert property ($rose(SERIAL_CLOCK_PIN) && IF_ENABLE && $past(IF_ENABLE) |-> PROM_CS)
      else $error("serial clock outside chip select");
   data_steady_a: assert property (SERIAL_CLOCK_PIN && $past(SERIAL_CLOCK_PIN) && IF_ENABLE &&
      $past(IF_ENABLE) && SERIAL_DATA_PIN_OE |-> $stable(SERIAL_DATA_PIN_O)) else $error("data moved in high phase");
   reload_clear_a: assert property (cmd_take && CMD_CODE_IN == `SEC_CMD_RELOAD |-> ##[1:2] !ADDR_LOADED)
      else $error("reload kept the loaded flag");
   soft_restart_a: assert property (SOFT_RESET |-> ##[1:2]
      (COMMAND_BUSY_FLAG && !ADDR_LOADED && !RESPONSE_TIMEOUT_FLAG)) else $error("soft reset did not restart load");
   loaded_c: cover property ($rose(ADDR_LOADED));
   timeout_c: cover property ($rose(RESPONSE_TIMEOUT_FLAG));
   reload_c: cover property (cmd_take && CMD_CODE_IN == `SEC_CMD_RELOAD);
   release_c: cover property (!IF_ENABLE ##1 !IF_ENABLE);
endmodule
bind sec_ctrl sec_ctrl_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.CLK, .RST, .SOFT_RESET, .IF_ENABLE,
   .GP_DATA_OUT, .GP_CLOCK_OUT, .CMD_WRITE, .CMD_CODE_IN, .CMD_LOCATION_IN, .CMD_BUSY_IN, .COMMAND_BUSY_FLAG,
   .COMMAND_CODE_FIELD, .LOCATION_FIELD, .RESPONSE_TIMEOUT_FLAG, .ADDR_LOADED, .PROM_CS, .SERIAL_CLOCK_PIN,
   .SERIAL_DATA_PIN_O, .SERIAL_DATA_PIN_OE);

// ---- test/sec_ctrl_tb.sv ----
// self-checking bench: controller against a reference copy of the eeprom contents
// assumes sec_prom_model as the far side and the checker bound to sec_ctrl
`timescale 1ns/10ps
`include "sec_regs.vh"
module sec_ctrl_tb;
   reg CLK = 0, RST = 1, SOFT_RESET = 0, IF_ENABLE = 1, GP_DATA_OUT = 0, GP_CLOCK_OUT = 0;
   reg CMD_WRITE = 0, CMD_BUSY_IN = 0, DATA_WRITE = 0, STA_WRITE_LOW = 0, STA_WRITE_HIGH = 0;
   reg [2:0] CMD_CODE_IN = 0;
   reg [6:0] CMD_LOCATION_IN = 0;
   reg [7:0] DATA_IN = 0;
   reg [31:0] STA_WDATA = 0;
   wire COMMAND_BUSY_FLAG, RESPONSE_TIMEOUT_FLAG, ADDR_LOADED, PROM_CS, SERIAL_CLOCK_PIN;
   wire SERIAL_DATA_PIN_O, SERIAL_DATA_PIN_OE, SERIAL_DATA_PIN_I, m_o, m_oe;
   wire [2:0] COMMAND_CODE_FIELD;
   wire [6:0] LOCATION_FIELD;
   wire [7:0] PROM_DATA;
   wire [31:0] STATION_ADDR_LOW;
   wire [15:0] STATION_ADDR_HIGH;
   integer seed = 81195, bad_count = 0, cmp_count = 0, i, n;
   reg [7:0] ref_mem [0:127];
   reg [47:0] sta_ref = 0;
   reg [7:0] dreg = 0;
   reg ref_en = 0, stall = 0, last = 0, poke = 0;
   always #4 CLK = ~CLK;
   always @(posedge CLK) last <= SERIAL_DATA_PIN_I;
   // a released line shows the inverse of its last level, so stale data cannot pass
   assign SERIAL_DATA_PIN_I = SERIAL_DATA_PIN_OE ? SERIAL_DATA_PIN_O : m_oe ? m_o : ~last;
   // short timeout keeps the run small; still above the longest frame plus the ready poll
   sec_ctrl #(.TIMEOUT_CYC(5000)) uut (.CLK, .RST, .SOFT_RESET, .IF_ENABLE, .GP_DATA_OUT, .GP_CLOCK_OUT,
      .CMD_WRITE, .CMD_CODE_IN, .CMD_LOCATION_IN, .CMD_BUSY_IN, .DATA_WRITE, .DATA_IN, .STA_WRITE_LOW,
      .STA_WRITE_HIGH, .STA_WDATA, .COMMAND_BUSY_FLAG, .COMMAND_CODE_FIELD, .LOCATION_FIELD,
      .RESPONSE_TIMEOUT_FLAG, .ADDR_LOADED, .PROM_DATA, .STATION_ADDR_LOW, .STATION_ADDR_HIGH, .PROM_CS,
      .SERIAL_CLOCK_PIN, .SERIAL_DATA_PIN_O, .SERIAL_DATA_PIN_OE, .SERIAL_DATA_PIN_I);
   sec_prom_model prom (.sclk(SERIAL_CLOCK_PIN), .cs(PROM_CS), .din(SERIAL_DATA_PIN_I), .stall(stall),
      .dq_o(m_o), .dq_oe(m_oe));
   task check(input [47:0] got, input [47:0] exp);
   begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
         bad_count = bad_count + 1;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task close_out;
   begin
      $display("compares %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   task tick;
   begin
      @(posedge CLK);
      #1;
   end
   endtask
   task wait_idle;
   begin
      n = 0;
      while (COMMAND_BUSY_FLAG !== 1'b0 && n < 30000)
      begin
         tick;
         n = n + 1;
      end
      check(n < 30000, 1);
   end
   endtask
   task load_chk;
   begin
      if (ref_mem[0] == `SEC_SIGNATURE)
         sta_ref = {ref_mem[6], ref_mem[5], ref_mem[4], ref_mem[3], ref_mem[2], ref_mem[1]};
      check(ADDR_LOADED, ref_mem[0] == `SEC_SIGNATURE);
      check({STATION_ADDR_HIGH, STATION_ADDR_LOW}, sta_ref);
   end
   endtask
   task setm(input [6:0] a, input [7:0] v);
   begin
      ref_mem[a] = v;
      prom.mem[a] = v;
   end
   endtask
   task wdata;
   begin
      tick;
      dreg = $random(seed);
      DATA_WRITE = 1;
      DATA_IN = dreg;
      tick;
      DATA_WRITE = 0;
   end
   endtask
   // ------------------------------------------------------------
   // one command, then the reference update and the comparisons
   // ------------------------------------------------------------
   task op(input [2:0] code, input [6:0] loc);
   begin
      tick;
      CMD_WRITE = 1;
      CMD_CODE_IN = code;
      CMD_LOCATION_IN = loc;
      CMD_BUSY_IN = 1;
      tick;
      CMD_WRITE = poke;
      CMD_CODE_IN = ~code;
      check(COMMAND_BUSY_FLAG, 1);
      tick;
      CMD_WRITE = 0;
      CMD_BUSY_IN = 0;
      check({COMMAND_CODE_FIELD, LOCATION_FIELD}, {code, loc});
      wait_idle;
      check(RESPONSE_TIMEOUT_FLAG, stall);
      for (i = 0; i < 128; i = i + 1)
         if (ref_en && (code == `SEC_CMD_WRITE_ALL_CMD || (code == `SEC_CMD_WRITE && i == loc)))
            ref_mem[i] = dreg;
         else if (ref_en && (code == `SEC_CMD_ERASE_ALL_CMD || (code == `SEC_CMD_ERASE && i == loc)))
            ref_mem[i] = 8'hff;
      if (code == `SEC_CMD_ERASE_WRITE_ENABLE_CMD || code == `SEC_CMD_ERASE_WRITE_DISABLE_CMD)
         ref_en = code == `SEC_CMD_ERASE_WRITE_ENABLE_CMD;
      if (code == `SEC_CMD_READ)
         check(PROM_DATA, ref_mem[loc]);
      if (code == `SEC_CMD_RELOAD)
         load_chk;
   end
   endtask
   initial
   begin
      #1000000;
      bad_count = bad_count + 1;
      close_out;
   end
   initial
   begin
      for (i = 0; i < 128; i = i + 1)
         setm(i, $random(seed));
      setm(`SEC_SIG_LOC, `SEC_SIGNATURE);
      repeat (5) @(posedge CLK);
      #1;
      RST = 0;
      wait_idle;
      load_chk;
      for (i = 1; i < 7; i = i + 1)
         setm(i, $random(seed));
      op(`SEC_CMD_RELOAD, 0);
      op(`SEC_CMD_ERASE_WRITE_ENABLE_CMD, 0);
      wdata;
      op(`SEC_CMD_WRITE, 127);
      op(`SEC_CMD_READ, 127);
      op(`SEC_CMD_ERASE, 127);
      poke = 1;
      op(`SEC_CMD_READ, 127);
      poke = 0;
      wdata;
      op(`SEC_CMD_WRITE_ALL_CMD, 0);
      op(`SEC_CMD_READ, $random(seed));
      op(`SEC_CMD_ERASE_ALL_CMD, 0);
      op(`SEC_CMD_READ, $random(seed));
      op(`SEC_CMD_RELOAD, 0);
      tick;
      STA_WDATA = $random(seed);
      {STA_WRITE_LOW, STA_WRITE_HIGH} = 2'h3;
      tick;
      {STA_WRITE_LOW, STA_WRITE_HIGH} = 2'h0;
      sta_ref = {STA_WDATA[15:0], STA_WDATA};
      SOFT_RESET = 1;
      tick;
      SOFT_RESET = 0;
      wait_idle;
      load_chk;
      stall = 1;
      wdata;
      op(`SEC_CMD_WRITE, 5);
      stall = 0;
      op(`SEC_CMD_ERASE_WRITE_DISABLE_CMD, 0);
      wdata;
      op(`SEC_CMD_WRITE, 3);
      op(`SEC_CMD_READ, 3);
      IF_ENABLE = 0;
      for (i = 0; i < 4; i = i + 1)
      begin
         {GP_DATA_OUT, GP_CLOCK_OUT} = i[1:0] ^ $random(seed);
         repeat (5) tick;
         check({SERIAL_DATA_PIN_OE, SERIAL_DATA_PIN_O, SERIAL_CLOCK_PIN}, {1'b1, GP_DATA_OUT, GP_CLOCK_OUT});
      end
      IF_ENABLE = 1;
      close_out;
   end
endmodule
